// *** hrw_device.sv ***
// device end: answers host reads with per-group ready stretching
`timescale 1ns/1ps
module hrw_device
  import hrw_pkg::*;
#(
  parameter int RAM_EXTRA_SEQ = 0,
  parameter int HEAVY_LIMIT = HRW_FRAME_ACC,
  parameter int FRAME_CYC = HRW_FRAME_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  hrw_if.device bus,
  output logic rd_req,
  output logic [HRW_GROUPS-1:0] rd_grp,
  output logic [HRW_ADDR_W-1:0] rd_addr,
  input wire logic [HRW_DATA_W-1:0] rd_data
);
  logic [HRW_GROUPS-1:0] sel_s;
  logic rd_s;
  logic [HRW_ADDR_W-1:0] addr_s;
  logic rd_d_ff;
  logic busy_ff;
  logic [HRW_SEQ_CNT_W-1:0] seq_left_ff;
  logic half_ff;
  logic [HRW_DATA_W-1:0] data_ff;
  logic [HRW_GROUPS-1:0] grp_ff;
  logic [$clog2(FRAME_CYC+1)-1:0] frame_ff;
  logic [HRW_GROUPS-1:0][7:0] acc_ff;
  logic start;
  logic heavy;
  hrw_space_t space;
  logic [HRW_SEQ_CNT_W-1:0] nxt_seq;

  hrw_sync #(.W(HRW_GROUPS + 1 + HRW_ADDR_W), .INIT({{HRW_GROUPS+1{1'b1}}, {HRW_ADDR_W{1'b0}}}))
    u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .d({bus.group_select_n, bus.rd_n, bus.addr}),
    .q({sel_s, rd_s, addr_s})
  );

  assign start = rd_d_ff && !rd_s && (sel_s != '1);
  assign space = hrw_space_t'(addr_s[HRW_ADDR_W-1 -: 2]);
  assign heavy = (acc_ff[0] >= HEAVY_LIMIT[7:0]) || (acc_ff[1] >= HEAVY_LIMIT[7:0])
    || (acc_ff[2] >= HEAVY_LIMIT[7:0]) || (acc_ff[3] >= HEAVY_LIMIT[7:0]);

  always_comb
  begin
    unique case (space)
      HRW_SP_INSTR: nxt_seq = HRW_SEQ_CNT_W'(HRW_INSTR_SEQ); // RULE_01
      HRW_SP_RAM: nxt_seq = heavy ? HRW_SEQ_CNT_W'(HRW_THROTTLE_SEQ) // RULE_03
        : HRW_SEQ_CNT_W'(HRW_RAM_SEQ + RAM_EXTRA_SEQ); // RULE_01
      default: nxt_seq = '0; // RULE_01
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rd_d_ff <= 1'b1;
    else
      rd_d_ff <= rd_s;
  end

  // countdown in sequencer cycles, each two core clocks
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      busy_ff <= 1'b0;
      seq_left_ff <= '0;
      half_ff <= 1'b0;
      grp_ff <= '0;
    end
    else if (start)
    begin
      busy_ff <= (nxt_seq != '0);
      seq_left_ff <= nxt_seq;
      half_ff <= 1'b0;
      grp_ff <= ~sel_s;
    end
    else if (busy_ff)
    begin
      half_ff <= ~half_ff; // RULE_02
      if (half_ff)
      begin
        seq_left_ff <= seq_left_ff - 1'b1;
        if (seq_left_ff == 1)
          busy_ff <= 1'b0;
      end
    end
    else if (rd_s)
      grp_ff <= '0;
  end

  // data latched at request, held until the next request
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      data_ff <= '0;
    else if (rd_req)
      data_ff <= rd_data; // RULE_07
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rd_req <= 1'b0;
    else
      rd_req <= start;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rd_grp <= '0;
      rd_addr <= '0;
    end
    else if (start)
    begin
      rd_grp <= ~sel_s;
      rd_addr <= addr_s;
    end
  end

  // data RAM accesses per group counted over one frame
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      frame_ff <= '0;
      acc_ff <= '0;
    end
    else if (frame_ff == FRAME_CYC - 1)
    begin
      frame_ff <= '0;
      acc_ff <= '0;
    end
    else
    begin
      frame_ff <= frame_ff + 1'b1;
      for (int g = 0; g < HRW_GROUPS; g++)
        if (start && !sel_s[g] && space == HRW_SP_RAM && acc_ff[g] != 8'hff)
          acc_ff[g] <= acc_ff[g] + 8'h01;
    end
  end

  // ready pulled low the cycle after start, held by the countdown or, for register reads, by the one-cycle rd_req, and released as that ends
  always_comb
  begin
    for (int g = 0; g < HRW_GROUPS; g++)
    begin
      bus.wait_release_oe[g] = !sel_s[g]; // RULE_08 RULE_10
      bus.wait_release_out[g] = !(grp_ff[g] && (busy_ff || rd_req || start)); // RULE_01
    end
  end

  assign bus.data_dev_out = data_ff;
  assign bus.data_dev_oe = !rd_s && (sel_s != '1) && !rd_req && !start; // RULE_09
endmodule : hrw_device

// *** hrw_host.sv ***
// host end: reads a group, waiting on ready or a fixed wait
`timescale 1ns/1ps
module hrw_host
  import hrw_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  hrw_if.host bus,
  input wire logic use_ready,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_group,
  input wire logic [HRW_ADDR_W-1:0] req_addr,
  output logic resp_valid,
  output logic [HRW_DATA_W-1:0] resp_data
);
  typedef enum logic [2:0]
  {
    HRW_H_IDLE = 3'b000,
    HRW_H_SEL = 3'b001,
    HRW_H_STROBE = 3'b010,
    HRW_H_WAIT = 3'b011,
    HRW_H_GAP = 3'b100
  } hrw_hstate_t;
  hrw_hstate_t state_ff;
  logic [15:0] cnt_ff;
  logic [HRW_GROUPS-1:0] wr_s;
  logic [HRW_DATA_W-1:0] data_s;
  logic [HRW_GROUPS-1:0] grp_ff;
  logic [HRW_GROUPS-1:0][4:0] acc_ff;
  logic [$clog2(HRW_FRAME_CYC+1)-1:0] frame_ff;
  logic grp_full;

  hrw_sync #(.W(HRW_GROUPS + HRW_DATA_W), .INIT({{HRW_GROUPS{1'b1}}, {HRW_DATA_W{1'b0}}}))
    u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .d({bus.wait_release_out | ~bus.wait_release_oe, bus.data_dev_out}),
    .q({wr_s, data_s})
  );

  assign grp_full = acc_ff[req_group] >= 5'(HRW_FRAME_ACC); // RULE_05
  assign req_ready = (state_ff == HRW_H_IDLE) && !grp_full;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_ff <= HRW_H_IDLE;
      cnt_ff <= '0;
      grp_ff <= '0;
      resp_valid <= 1'b0;
      resp_data <= '0;
      bus.group_select_n <= '1;
      bus.rd_n <= 1'b1;
      bus.addr <= '0;
    end
    else
    begin
      resp_valid <= 1'b0;
      unique case (state_ff)
        HRW_H_IDLE:
          if (req_valid && req_ready)
          begin
            grp_ff <= HRW_GROUPS'(1) << req_group;
            bus.addr <= req_addr;
            bus.group_select_n <= ~(HRW_GROUPS'(1) << req_group); // RULE_10
            state_ff <= HRW_H_SEL;
          end
        HRW_H_SEL:
        begin
          bus.rd_n <= 1'b0;
          cnt_ff <= 16'(HRW_HOST_WAIT_CYC); // RULE_04
          state_ff <= HRW_H_STROBE;
        end
        // let the device's ready fall through its sync stages
        HRW_H_STROBE:
        begin
          cnt_ff <= cnt_ff - 16'h0001;
          if (cnt_ff <= 16'(HRW_HOST_WAIT_CYC - 6))
            state_ff <= HRW_H_WAIT;
        end
        HRW_H_WAIT:
        begin
          if (cnt_ff != 0)
            cnt_ff <= cnt_ff - 16'h0001;
          if (use_ready ? ((wr_s & grp_ff) != 0) : (cnt_ff == 0)) // RULE_11
          begin
            resp_data <= data_s; // RULE_11
            resp_valid <= 1'b1;
            bus.rd_n <= 1'b1;
            bus.group_select_n <= '1;
            cnt_ff <= 16'(HRW_GAP_CYC); // RULE_06
            state_ff <= HRW_H_GAP;
          end
        end
        HRW_H_GAP:
        begin
          cnt_ff <= cnt_ff - 16'h0001;
          if (cnt_ff == 1)
            state_ff <= HRW_H_IDLE; // RULE_06
        end
        default: state_ff <= HRW_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      frame_ff <= '0;
      acc_ff <= '0;
    end
    else if (frame_ff == HRW_FRAME_CYC - 1)
    begin
      frame_ff <= '0;
      acc_ff <= '0; // RULE_05
    end
    else
    begin
      frame_ff <= frame_ff + 1'b1;
      if (state_ff == HRW_H_IDLE && req_valid && req_ready)
        acc_ff[req_group] <= acc_ff[req_group] + 5'h01; // RULE_05
    end
  end
endmodule : hrw_host

// *** hrw_if.sv ***
// interface joining the host and device ends of the read port
`timescale 1ns/1ps
interface hrw_if;
  import hrw_pkg::*;
  logic [HRW_GROUPS-1:0] group_select_n;
  logic rd_n;
  logic [HRW_ADDR_W-1:0] addr;
  logic [HRW_DATA_W-1:0] data_dev_out;
  logic data_dev_oe;
  logic [HRW_GROUPS-1:0] wait_release_out;
  logic [HRW_GROUPS-1:0] wait_release_oe;
  modport device (
    input group_select_n, rd_n, addr,
    output data_dev_out, data_dev_oe, wait_release_out, wait_release_oe
  );
  modport host (
    output group_select_n, rd_n, addr,
    input data_dev_out, data_dev_oe, wait_release_out, wait_release_oe
  );
endinterface : hrw_if

// *** hrw_pkg.sv ***
// package of constants and types for the host read wait handshake
// How it works
// [RULE_01] ready low: none, 6-7, 9-33 sequencer cycles (register reads still hold ready low for one core clock)
// [RULE_02] one sequencer cycle is two core clocks
// [RULE_03] heavy data RAM use stretches wait to 97
// [RULE_04] ready-blind host waits about 640 ns
// [RULE_05] at most 16 accesses per group per frame
// [RULE_06] at least 600 ns between group accesses
// [RULE_07] read data valid when ready rises
// [RULE_08] ready driven only while group selected
// [RULE_09] data driven from strobe fall to rise
// [RULE_10] four groups, each select and ready
// [RULE_11] host holds strobe until ready, then captures
package hrw_pkg;
  localparam int HRW_GROUPS = 4;
  localparam int HRW_DATA_W = 8;
  localparam int HRW_ADDR_W = 12;
  localparam int HRW_CLK_PERIOD_PS = 25000;
  localparam int HRW_CLK_PER_SEQ = 2;
  localparam int HRW_INSTR_SEQ = 6;
  localparam int HRW_RAM_SEQ = 9;
  localparam int HRW_RAM_MAX_SEQ = 33;
  localparam int HRW_THROTTLE_SEQ = 97;
  localparam int HRW_HOST_WAIT_NS = 640;
  localparam int HRW_HOST_WAIT_CYC =
    (HRW_HOST_WAIT_NS * 1000 + HRW_CLK_PERIOD_PS - 1) / HRW_CLK_PERIOD_PS;
  localparam int HRW_GAP_NS = 600;
  localparam int HRW_GAP_CYC = (HRW_GAP_NS * 1000 + HRW_CLK_PERIOD_PS - 1) / HRW_CLK_PERIOD_PS;
  localparam int HRW_FRAME_NS = 125000;
  localparam int HRW_FRAME_CYC = (HRW_FRAME_NS * 1000) / HRW_CLK_PERIOD_PS;
  localparam int HRW_FRAME_ACC = 16;
  localparam int HRW_SEQ_CNT_W = 8;
  localparam logic [1:0] HRW_SPACE_HI = 2'h3;
  typedef enum logic [1:0]
  {
    HRW_SP_REG = 2'b00,
    HRW_SP_INSTR = 2'b01,
    HRW_SP_RAM = 2'b10
  } hrw_space_t;
endpackage : hrw_pkg

// *** hrw_props.sv ***
// checker of wire-level rules on the host read port
`timescale 1ns/1ps
module hrw_props
  import hrw_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [HRW_GROUPS-1:0] group_select_n,
  input wire logic rd_n,
  input wire logic [HRW_ADDR_W-1:0] addr,
  input wire logic [HRW_DATA_W-1:0] data_dev_out,
  input wire logic data_dev_oe,
  input wire logic [HRW_GROUPS-1:0] wait_release_out,
  input wire logic [HRW_GROUPS-1:0] wait_release_oe
);
  logic low_any;
  logic [7:0] lo_cnt_ff;
  logic [7:0] idle_cnt_ff;
  assign low_any = |(wait_release_oe & ~wait_release_out);
  // counters saturate so long idle spells never wrap into false gaps
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !low_any) lo_cnt_ff <= 8'h00;
    else if (lo_cnt_ff != 8'hff) lo_cnt_ff <= lo_cnt_ff + 8'h01;
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) idle_cnt_ff <= 8'hff;
    else if (!(&group_select_n)) idle_cnt_ff <= 8'h00;
    else if (idle_cnt_ff != 8'hff) idle_cnt_ff <= idle_cnt_ff + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    $rose(low_any);
  endsequence
  sequence s_reg;
    s_start ##0 addr[11:10] == 2'h0;
  endsequence
  sequence s_instr;
    s_start ##0 addr[11:10] == 2'h1;
  endsequence
  sequence s_ram;
    s_start ##0 addr[11:10] == 2'h2;
  endsequence
  AST_REG_NOWAIT: assert property (s_reg |-> ##[1:3] !low_any)
    else $error("register read stretched");
  AST_INSTR_MIN: assert property (s_instr |-> ##11 low_any)
    else $error("instruction wait too short");
  AST_INSTR_MAX: assert property (s_instr |-> ##[12:15] !low_any)
    else $error("instruction wait too long");
  AST_RAM_MIN: assert property (s_ram |-> ##17 low_any)
    else $error("data ram wait too short");
  AST_WAIT_CAP: assert property (lo_cnt_ff <= 8'd195)
    else $error("wait beyond throttle limit");
  AST_DATA_AT_READY: assert property ($fell(low_any) && !rd_n |-> data_dev_oe ##1 $stable(data_dev_out))
    else $error("data not valid at ready");
  AST_READY_FLOAT: assert property ((&group_select_n) [*4] |-> wait_release_oe == 4'h0)
    else $error("ready driven while unselected");
  AST_DATA_FLOAT: assert property (rd_n [*4] |-> !data_dev_oe)
    else $error("data driven with strobe high");
  AST_DATA_DRIVE: assert property ($fell(rd_n) |-> ##[1:6] data_dev_oe)
    else $error("data not driven after strobe");
  AST_HOST_HOLD: assert property (!rd_n && low_any |=> !rd_n)
    else $error("strobe released during wait");
  AST_GAP: assert property ($fell(&group_select_n) |-> idle_cnt_ff >= 8'(HRW_GAP_CYC - 4))
    else $error("access gap too short");
  AST_ONE_GROUP: assert property ($onehot0(~group_select_n))
    else $error("two groups selected");
endmodule : hrw_props

// *** hrw_sync.sv ***
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module hrw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta_ff <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : hrw_sync

// *** testbench.sv ***
// self-checking bench joining host and device ends of the read port
`timescale 1ns/1ps
module testbench;
  import hrw_pkg::*;
  logic core_clk, sys_rst, use_ready, req_valid, req_ready, resp_valid, rd_req;
  logic [1:0] req_group;
  logic [HRW_ADDR_W-1:0] req_addr, rd_addr;
  logic [HRW_DATA_W-1:0] resp_data, rd_data;
  logic [HRW_GROUPS-1:0] rd_grp;
  int err_total, n_checks, lo_c, rd_c, cyc;
  hrw_if bus_if();
  // small heavy limit and frame so the throttle is reached quickly
  hrw_device #(.RAM_EXTRA_SEQ(0), .HEAVY_LIMIT(2), .FRAME_CYC(4000)) hrw_device_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .bus(bus_if), .rd_req(rd_req),
    .rd_grp(rd_grp), .rd_addr(rd_addr), .rd_data(rd_data));
  hrw_host hrw_host_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus_if),
    .use_ready(use_ready), .req_valid(req_valid), .req_ready(req_ready),
    .req_group(req_group), .req_addr(req_addr), .resp_valid(resp_valid),
    .resp_data(resp_data));
  hrw_props hrw_props_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .group_select_n(bus_if.group_select_n), .rd_n(bus_if.rd_n), .addr(bus_if.addr),
    .data_dev_out(bus_if.data_dev_out), .data_dev_oe(bus_if.data_dev_oe),
    .wait_release_out(bus_if.wait_release_out), .wait_release_oe(bus_if.wait_release_oe));
  assign rd_data = rd_addr[7:0] ^ 8'h5a;
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi)
    begin
      err_total++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, v);
    end
  endtask : chk_rng
  // one read; counts ready-low and strobe-low cycles of the chosen group
  task automatic rd(input logic [1:0] g, input logic [11:0] a, input logic ur);
    int k;
    use_ready = ur;
    req_group = g;
    req_addr = a;
    req_valid = 1'b1;
    k = 0;
    lo_c = 0;
    rd_c = 0;
    // look at req_ready while settled, then let the taking edge pass
    while (req_ready !== 1'b1 && k < 200)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    for (k = 0; k < 400 && resp_valid !== 1'b1; k++)
    begin
      @(posedge core_clk);
      #1;
      if (bus_if.wait_release_oe[g] && !bus_if.wait_release_out[g]) lo_c++;
      if (!bus_if.rd_n) rd_c++;
    end
    chk("resp_valid", 32'h1, 32'(resp_valid));
    chk("resp_data", 32'(a[7:0] ^ 8'h5a), 32'(resp_data));
    chk("rd_grp", 32'(4'h1 << g), 32'(rd_grp));
  endtask : rd
  initial
  begin
    int g;
    int k;
    sys_rst = 1'b1;
    use_ready = 1'b1;
    req_valid = 1'b0;
    req_group = 2'h0;
    req_addr = 12'h000;
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    for (g = 0; g < HRW_GROUPS; g++)
    begin
      rd(2'(g), 12'h010 + 12'(g), 1'b1);
      chk_rng("reg wait", lo_c, 0, 2);
    end
    $display("test register reads done");
    rd(2'h1, 12'h4a5, 1'b1);
    chk_rng("instr wait", lo_c, 12, 15);
    rd(2'h2, 12'h83c, 1'b1);
    chk_rng("ram wait", lo_c, 18, 67);
    $display("test stretched reads done");
    rd(2'h0, 12'h4c3, 1'b0);
    chk_rng("fixed strobe", rd_c, HRW_HOST_WAIT_CYC, HRW_HOST_WAIT_CYC + 2);
    $display("test fixed wait done");
    for (g = 0; g < 4; g++) rd(2'h1, 12'h840 + 12'(g), 1'b1);
    chk_rng("throttled wait", lo_c, 68, 195);
    $display("test throttle done");
    for (g = 0; g < HRW_FRAME_ACC - 1; g++) rd(2'h3, 12'h020, 1'b1);
    req_group = 2'h3;
    req_valid = 1'b1;
    k = 0;
    repeat (60)
    begin
      @(posedge core_clk);
      if (req_ready) k++;
    end
    #1;
    req_valid = 1'b0;
    chk_rng("frame refusal", k, 0, 0);
    $display("test frame limit done");
    conclude();
  end
endmodule : testbench
